// [verilog/tcm_pkg.sv]
package tcm_pkg;

	// ------------------------------------------------------------------
	// Clock rates and prescaler shape
	// ------------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ = 50_000_000;
	localparam int unsigned LOW_CLK_HZ = 32_768;
	// Low clock enable is made from the system clock by rounding division
	localparam int unsigned LOW_DIV =
		(SYS_CLK_HZ + LOW_CLK_HZ / 2) / LOW_CLK_HZ;
	localparam int unsigned HF_W   = 11;
	localparam int unsigned SH_S0  = 11;
	localparam int unsigned SH_S1  = 7;
	localparam int unsigned SH_S2  = 5;
	localparam int unsigned SH_S3  = 3;
	localparam int unsigned SH_H2  = 1;
	localparam int unsigned SH_H1  = 0;

	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;
	localparam logic [2:0] OFS_CONTROL = 3'h0;
	localparam logic [2:0] OFS_COMPARE = 3'h1;
	localparam logic [2:0] OFS_COUNT   = 3'h2;
	localparam logic [2:0] OFS_STATUS  = 3'h3;
	localparam logic [2:0] OFS_MASK    = 3'h4;
	localparam logic [2:0] OFS_SYSCTL  = 3'h5;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int unsigned CTL_FF_BIT   = 7;
	localparam int unsigned CTL_SEL_LSB  = 4;
	localparam int unsigned CTL_RUN_BIT  = 3;
	localparam int unsigned CTL_MODE_LSB = 0;
	localparam int unsigned SYS_PSEL_BIT = 0;
	localparam int unsigned SYS_LOW_BIT  = 1;
	localparam int unsigned IRQ_MATCH    = 0;

	// ------------------------------------------------------------------
	// Modes and clock slots
	// ------------------------------------------------------------------
	localparam logic [2:0] MODE_TIMER   = 3'h0;
	localparam logic [2:0] MODE_DIVIDER = 3'h1;
	localparam logic [2:0] SEL_SLOT0 = 3'h0;
	localparam logic [2:0] SEL_SLOT1 = 3'h1;
	localparam logic [2:0] SEL_SLOT2 = 3'h2;
	localparam logic [2:0] SEL_SLOT3 = 3'h3;
	localparam logic [2:0] SEL_LOW   = 3'h4;
	localparam logic [2:0] SEL_HALF  = 3'h5;
	localparam logic [2:0] SEL_FULL  = 3'h6;
	localparam logic [2:0] SEL_PIN   = 3'h7;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_COMPARE = 8'h00;
	localparam logic [7:0] RST_MASK    = 8'h00;

endpackage : tcm_pkg

// [verilog/tcm_presc_if.sv]
`timescale 1ns/100ps
interface tcm_presc_if;
	import tcm_pkg::*;
	logic [HF_W:0] hf_tick;
	logic          lf_tick;
	logic          lf8_tick;
	modport gen (output hf_tick, output lf_tick, output lf8_tick);
	modport use_side (input hf_tick, input lf_tick, input lf8_tick);
endinterface : tcm_presc_if

// [verilog/tcm_prescaler.sv]
`timescale 1ns/100ps
module tcm_prescaler #(
	parameter int unsigned LOW_DIV_P = tcm_pkg::LOW_DIV
) (
	input  wire logic     i_sys_clk,
	input  wire logic     i_rst_n,
	tcm_presc_if.gen      o_presc
);
	import tcm_pkg::*;

	localparam int unsigned LW = $clog2(LOW_DIV_P);

	typedef struct packed {
		logic [HF_W-1:0] hf_cnt;
		logic [LW-1:0]   lf_cnt;
		logic [2:0]      lf8_cnt;
	} tcm_presc_t;

	tcm_presc_t st;
	tcm_presc_t next_st;
	logic       lf_wrap;

	// ------------------------------------------------------------------
	// Tick decode
	// ------------------------------------------------------------------
	// Full rate enable is always on
	assign o_presc.hf_tick[0] = 1'b1;
	genvar k;
	generate
		for (k = 1; k <= HF_W; k++) begin : g_hf
			// Divided by 2^k once per wrap of the low k bits
			assign o_presc.hf_tick[k] = &st.hf_cnt[k-1:0];
		end
	endgenerate
	assign lf_wrap           = (st.lf_cnt == LW'(LOW_DIV_P - 1));
	assign o_presc.lf_tick   = lf_wrap;
	assign o_presc.lf8_tick  = lf_wrap && (&st.lf8_cnt);

	// Next state of the dividers
	always_comb begin
		next_st        = st;
		next_st.hf_cnt = st.hf_cnt + 1'b1;
		if (lf_wrap) begin
			next_st.lf_cnt  = '0;
			next_st.lf8_cnt = st.lf8_cnt + 1'b1;
		end else begin
			next_st.lf_cnt = st.lf_cnt + 1'b1;
		end
	end

	// Divider registers
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule : tcm_prescaler

// [verilog/tcm_timer.sv]
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module tcm_timer #(
	parameter int unsigned LOW_DIV_P = tcm_pkg::LOW_DIV
) (
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_nrst,
	input  wire logic [tcm_pkg::ADDR_W-1:0]  i_addr,
	input  wire logic [tcm_pkg::DATA_W-1:0]  i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [tcm_pkg::DATA_W-1:0]  o_rdata,
	input  wire logic                        i_event_input_pin,
	output logic                             o_divider_out_pin,
	output logic                             o_match_irq
);
	import tcm_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        run;
		logic        ff_state;
		logic [2:0]  mode;
		logic [2:0]  clk_sel;
		logic [7:0]  cmp;
		logic [7:0]  count;
		logic        presc_sel;
		logic        low_speed;
		logic        status;
		logic        mask;
		logic        irq;
		logic        pin;
		logic [7:0]  rdata;
		logic        ev_s1;
		logic        ev_s2;
		logic        ev_s3;
	} tcm_state_t;

	localparam tcm_state_t ST_RST = '{
		pin     : 1'b1,
		cmp     : RST_COMPARE,
		default : '0
	};

	tcm_state_t  st;
	tcm_state_t  next_st;
	logic [1:0]  rst_sync;
	logic        rst_n;
	logic        src_tick;
	logic        ev_fall;
	logic        active;
	logic        step;
	logic        match;
	logic [7:0]  inc;
	logic        wr_ctl;
	logic        wr_cmp;
	logic        wr_sts;
	logic        wr_msk;
	logic        wr_sys;

	tcm_presc_if presc ();

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	// Two stage release so the rest of the block leaves reset cleanly
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------
	tcm_prescaler #(
		.LOW_DIV_P (LOW_DIV_P)
	) u_presc (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (rst_n),
		.o_presc   (presc.gen)
	);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Write strobe aimed at one register offset
	function automatic logic wr_hit(input logic wr,
			input logic [ADDR_W-1:0] addr,
			input logic [ADDR_W-1:0] ofs);
		wr_hit = wr && (addr == ofs);
	endfunction : wr_hit

	assign wr_ctl = wr_hit(i_wr, i_addr, OFS_CONTROL);
	assign wr_cmp = wr_hit(i_wr, i_addr, OFS_COMPARE);
	assign wr_sts = wr_hit(i_wr, i_addr, OFS_STATUS);
	assign wr_msk = wr_hit(i_wr, i_addr, OFS_MASK);
	assign wr_sys = wr_hit(i_wr, i_addr, OFS_SYSCTL);

	// Falling edge seen between the last two synchronised samples
	assign ev_fall = st.ev_s3 && !st.ev_s2;

	// ------------------------------------------------------------------
	// Source clock slot
	// ------------------------------------------------------------------
	// Slowest slot swaps to low clock over 8 when selected or slow running
	always_comb begin
		unique case (st.clk_sel)
			SEL_SLOT0: src_tick = (st.presc_sel || st.low_speed) ?
				presc.lf8_tick : presc.hf_tick[SH_S0];
			SEL_SLOT1: src_tick = presc.hf_tick[SH_S1];
			SEL_SLOT2: src_tick = presc.hf_tick[SH_S2];
			SEL_SLOT3: src_tick = presc.hf_tick[SH_S3];
			SEL_LOW:   src_tick = presc.lf_tick;
			SEL_HALF:  src_tick = presc.hf_tick[SH_H2];
			SEL_FULL:  src_tick = presc.hf_tick[SH_H1];
			SEL_PIN:   src_tick = ev_fall;
		endcase
	end

	// ------------------------------------------------------------------
	// Counter core
	// ------------------------------------------------------------------
	// Only the two 8-bit modes count; other codes leave the counter idle
	assign active = st.run &&
		(st.mode == MODE_TIMER || st.mode == MODE_DIVIDER);
	assign step   = active && src_tick;
	assign inc    = st.count + 8'h01;
	// Compare value is read live, no shadow copy
	assign match  = step && (inc == st.cmp);

	// Next state of counter, flop, registers and read data
	always_comb begin
		next_st       = st;
		next_st.rdata = 8'h00;
		// Pin sampler chain
		next_st.ev_s1 = i_event_input_pin;
		next_st.ev_s2 = st.ev_s1;
		next_st.ev_s3 = st.ev_s2;
		// Count on each tick, clear on match and keep going
		if (step) begin
			next_st.count = match ? 8'h00 : inc;
		end
		// Divider mode flips the output flop at every match
		if (match && st.mode == MODE_DIVIDER) begin
			next_st.ff_state = ~st.ff_state;
		end
		// Control write; preset only lands while stopped before the write
		if (wr_ctl) begin
			next_st.run     = i_wdata[CTL_RUN_BIT];
			next_st.mode    = i_wdata[CTL_MODE_LSB +: 3];
			next_st.clk_sel = i_wdata[CTL_SEL_LSB +: 3];
			if (!st.run) begin
				next_st.ff_state = i_wdata[CTL_FF_BIT];
			end
		end
		// Stopped counter sits at zero
		if (!next_st.run) begin
			next_st.count = 8'h00;
		end
		if (wr_cmp) begin
			next_st.cmp = i_wdata;
		end
		if (wr_msk) begin
			next_st.mask = i_wdata[IRQ_MATCH];
		end
		if (wr_sys) begin
			next_st.presc_sel = i_wdata[SYS_PSEL_BIT];
			next_st.low_speed = i_wdata[SYS_LOW_BIT];
		end
		// Write one clears; a match in the same cycle wins
		if (wr_sts && i_wdata[IRQ_MATCH]) begin
			next_st.status = 1'b0;
		end
		if (match) begin
			next_st.status = 1'b1;
		end
		next_st.irq = next_st.status && next_st.mask;
		// Pin mirrors the flop inverted
		next_st.pin = ~next_st.ff_state;
		// Read data for the cycle after the strobe
		if (i_rd) begin
			unique case (i_addr)
				OFS_CONTROL: next_st.rdata = {st.ff_state, st.clk_sel,
					st.run, st.mode};
				OFS_COMPARE: next_st.rdata = st.cmp;
				OFS_COUNT:   next_st.rdata = st.count;
				OFS_STATUS:  next_st.rdata = {7'h00, st.status};
				OFS_MASK:    next_st.rdata = {7'h00, st.mask};
				OFS_SYSCTL:  next_st.rdata = {6'h00, st.low_speed,
					st.presc_sel};
				default:     next_st.rdata = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign o_rdata           = st.rdata;
	assign o_divider_out_pin = st.pin;
	assign o_match_irq       = st.irq;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!rst_n);

	// Match in timer mode clears the count and flags the event
	timer_match_a: assert property (
		(active && src_tick && inc == st.cmp && st.mode == MODE_TIMER
			&& !wr_ctl)
		|=> (st.count == 8'h00) && st.status)
		else $error("timer match did not clear and flag");

	// Event mode advances by one per falling edge short of a match
	event_step_a: assert property (
		(st.run && st.mode == MODE_TIMER && st.clk_sel == SEL_PIN
			&& ev_fall && inc != st.cmp && !wr_ctl)
		|=> st.count == $past(st.count) + 8'h01)
		else $error("event edge did not advance count");

	// Divider match flips the flop and clears the count one cycle later
	divider_toggle_a: assert property (
		(match && st.mode == MODE_DIVIDER && !wr_ctl)
		|=> (st.ff_state != $past(st.ff_state)) && st.count == 8'h00)
		else $error("divider match did not toggle");

	// Pin is the inverse of the flop at all times
	pin_inverse_a: assert property (
		o_divider_out_pin == !st.ff_state)
		else $error("divider pin not inverse of flop");

	// Preset write while stopped loads the flop
	preset_load_a: assert property (
		(wr_ctl && !st.run)
		|=> st.ff_state == $past(i_wdata[CTL_FF_BIT]))
		else $error("preset write did not load flop");

	// Stopped timer holds its pin until a control write
	stop_hold_a: assert property (
		(!st.run && !wr_ctl) |=> $stable(o_divider_out_pin))
		else $error("pin moved while stopped");

	// Compare write is visible the next cycle
	compare_live_a: assert property (
		wr_cmp |=> st.cmp == $past(i_wdata))
		else $error("compare write not immediate");

	// Swapped slowest slot follows the low clock over 8
	slot_swap_a: assert property (
		(st.clk_sel == SEL_SLOT0 && st.presc_sel)
		|-> src_tick == presc.lf8_tick)
		else $error("slowest slot not low clock over 8");

	// A stopped counter reads zero and never counts
	stop_clear_a: assert property (
		!st.run |-> st.count == 8'h00)
		else $error("stopped counter not cleared");

	// Undefined mode codes leave the count at rest
	mode_idle_a: assert property (
		(st.run && st.mode != MODE_TIMER && st.mode != MODE_DIVIDER
			&& !wr_ctl) |=> $stable(st.count))
		else $error("count moved in an idle mode");

	// Edge is taken from synchronised samples three cycles late
	edge_sync_a: assert property (
		ev_fall |-> $past(i_event_input_pin, 3)
			&& !$past(i_event_input_pin, 2))
		else $error("edge not from synchronised samples");

	// Set wins over write one clear
	status_set_a: assert property (
		(match && wr_sts && i_wdata[IRQ_MATCH]) |=> st.status)
		else $error("match lost against clear");

	// Interrupt line follows masked status
	irq_level_a: assert property (
		o_match_irq == (st.status && st.mask))
		else $error("irq not masked status");

	// Low speed system mode also moves the slowest slot to low clock / 8
	slow_swap_a: assert property (
		(st.clk_sel == SEL_SLOT0 && st.low_speed)
		|-> src_tick == presc.lf8_tick)
		else $error("low speed slot not low clock over 8");

	// Timer mode advances by one per selected tick short of a match
	timer_step_a: assert property (
		(step && st.mode == MODE_TIMER && st.clk_sel != SEL_PIN
			&& !match && !wr_ctl)
		|=> st.count == $past(st.count) + 8'h01)
		else $error("timer tick did not advance count");

	// Without a selected tick a running count keeps its value
	count_hold_a: assert property (
		(st.run && !src_tick && !wr_ctl) |=> $stable(st.count))
		else $error("count moved without a tick");

	// Flop moves only on a divider match or a preset write while stopped
	flop_hold_a: assert property (
		(!(match && st.mode == MODE_DIVIDER) && !(wr_ctl && !st.run))
		|=> $stable(st.ff_state))
		else $error("flop moved without match or preset");

	// Read data stand only in the cycle after a read strobe
	rdata_idle_a: assert property (
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read cycle");

endmodule : tcm_timer

// [tb/tcm_evt_src.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Event pulse source on the counter's external pin
// ----------------------------------------------------------------------
module tcm_evt_src (
	input  wire logic i_sys_clk,
	output logic      o_event_input_pin
);
	// Pin idles high, like a line with a pull-up
	initial o_event_input_pin = 1'b1;

	// Pulses start 3 ns after an edge, so they are unrelated to sampling
	task automatic pulses(input int n, input int w);
		repeat (n) begin
			repeat (w) @(posedge i_sys_clk);
			#3 o_event_input_pin = 1'b0;
			repeat (w) @(posedge i_sys_clk);
			#3 o_event_input_pin = 1'b1;
		end
	endtask : pulses
endmodule : tcm_evt_src

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
	import tcm_pkg::*;

	// ------------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------------
	localparam int LDIV = 4;
	logic              i_sys_clk;
	logic              i_nrst;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata;
	logic              i_wr;
	logic              i_rd;
	logic [DATA_W-1:0] o_rdata;
	logic              evt_pin;
	logic              o_divider_out_pin;
	logic              o_match_irq;
	logic [7:0]        exp_q[$];
	logic              rd_q;
	logic [7:0]        ctl;
	int                n_errors;
	int                samples_checked;
	logic [7:0] sys_t [10] = '{0, 1, 2, 0, 0, 0, 0, 0, 0, 0};
	logic [2:0] sel_t [10] = '{SEL_SLOT0, SEL_SLOT0, SEL_SLOT0, SEL_SLOT1,
		SEL_SLOT2, SEL_SLOT3, SEL_LOW, SEL_HALF, SEL_FULL, SEL_FULL};
	logic [7:0] cmp_t [10] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 8'hff};
	int         per_t [10] = '{2048, 8 * LDIV, 8 * LDIV, 128, 32, 8, LDIV,
		2, 1, 255};

	tcm_timer #(.LOW_DIV_P(LDIV)) tcm_timer_i (
		.i_sys_clk         (i_sys_clk),
		.i_nrst            (i_nrst),
		.i_addr            (i_addr),
		.i_wdata           (i_wdata),
		.i_wr              (i_wr),
		.i_rd              (i_rd),
		.o_rdata           (o_rdata),
		.i_event_input_pin (evt_pin),
		.o_divider_out_pin (o_divider_out_pin),
		.o_match_irq       (o_match_irq)
	);
	tcm_evt_src tcm_evt_src_i (
		.i_sys_clk         (i_sys_clk),
		.o_event_input_pin (evt_pin)
	);

	// Clock
	initial i_sys_clk = 1'b0;
	always #10 i_sys_clk = ~i_sys_clk;

	// ------------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	// Read data stands only in the cycle after the strobe
	always @(posedge i_sys_clk) begin
		if (rd_q) begin
			check("read data", {8'h00, o_rdata}, {8'h00, exp_q.pop_front()});
		end
		rd_q <= i_rd;
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_sys_clk);
		i_wr    <= 1'b0;
		@(posedge i_sys_clk);
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_sys_clk);
		i_rd   <= 1'b0;
		@(posedge i_sys_clk);
	endtask : rd

	// Stop with settings untouched, then reprogram and start
	task automatic start(input logic [2:0] sel, input logic [2:0] mode,
			input logic [7:0] cmp);
		ctl[3] = 1'b0;
		wr(OFS_CONTROL, ctl);
		ctl = {ctl[7], sel, 1'b0, mode};
		wr(OFS_CONTROL, ctl);
		wr(OFS_COMPARE, cmp);
		ctl[3] = 1'b1;
		wr(OFS_CONTROL, ctl);
	endtask : start

	// Cycles until the divider pin changes, bounded
	task automatic edge_wait(output int n);
		logic p;
		p = o_divider_out_pin;
		n = 0;
		while (o_divider_out_pin === p && n < 5000) begin
			@(posedge i_sys_clk);
			n++;
		end
		if (n >= 5000) begin
			check("divider pin edge", 16'h0, 16'h1);
			end_of_test();
		end
	endtask : edge_wait

	// The first interval may be partial, so the second one is measured
	task automatic period(input int e);
		int n;
		edge_wait(n);
		edge_wait(n);
		check("divider half period", n[15:0], e[15:0]);
	endtask : period

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		int   n;
		logic p;
		i_nrst = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		rd_q = 1'b0;
		ctl = 8'h00;
		n_errors = 0;
		samples_checked = 0;
		n = $urandom(32'hc1db);
		repeat (16) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		// Reset values, unmapped places, compare readback
		check("pin after reset", {15'h0, o_divider_out_pin}, 16'h1);
		check("irq after reset", {15'h0, o_match_irq}, 16'h0);
		rd(OFS_COMPARE, RST_COMPARE);
		rd(OFS_MASK, RST_MASK);
		rd(OFS_STATUS, 8'h00);
		wr(3'h7, 8'hff);
		rd(3'h7, 8'h00);
		rd(3'h6, 8'h00);
		wr(OFS_COMPARE, 8'h2a);
		rd(OFS_COMPARE, 8'h2a);
		// Every clock slot but the pin in divider mode, and the top compare value
		// Divider pin is taken as routed out with its port latch set
		for (int i = 0; i < 10; i++) begin
			wr(OFS_SYSCTL, sys_t[i]);
			start(sel_t[i], MODE_DIVIDER, cmp_t[i]);
			period(per_t[i]);
		end
		// Random compare values on the full-rate slot
		repeat (3) begin
			n = 1 + ($urandom % 40);
			start(SEL_FULL, MODE_DIVIDER, n[7:0]);
			period(n);
		end
		// Stop holds the pin and clears the count, then preset both ways
		start(SEL_FULL, MODE_DIVIDER, 8'h03);
		repeat (7) @(posedge i_sys_clk);
		ctl[3] = 1'b0;
		wr(OFS_CONTROL, ctl);
		p = o_divider_out_pin;
		repeat (20) @(posedge i_sys_clk);
		check("pin held", {15'h0, o_divider_out_pin}, {15'h0, p});
		rd(OFS_COUNT, 8'h00);
		ctl[7] = 1'b1;
		wr(OFS_CONTROL, ctl);
		check("pin preset 1", {15'h0, o_divider_out_pin}, 16'h0);
		rd(OFS_CONTROL, {1'b1, SEL_FULL, 1'b0, MODE_DIVIDER});
		ctl[7] = 1'b0;
		wr(OFS_CONTROL, ctl);
		check("pin preset 0", {15'h0, o_divider_out_pin}, 16'h1);
		// Timer mode: match interrupt, pin untouched, mask and clear
		wr(OFS_STATUS, 8'h01);
		wr(OFS_MASK, 8'h01);
		p = o_divider_out_pin;
		start(SEL_FULL, MODE_TIMER, 8'h05);
		n = 0;
		while (o_match_irq !== 1'b1 && n < 50) begin
			@(posedge i_sys_clk);
			n++;
		end
		check("irq delay", {15'h0, n >= 4 && n <= 8}, 16'h1);
		if (n >= 50) begin
			end_of_test();
		end
		repeat (12) @(posedge i_sys_clk);
		check("pin in timer", {15'h0, o_divider_out_pin}, {15'h0, p});
		start(SEL_FULL, MODE_TIMER, 8'h05);
		ctl[3] = 1'b0;
		wr(OFS_CONTROL, ctl);
		wr(OFS_MASK, 8'h00);
		check("masked irq", {15'h0, o_match_irq}, 16'h0);
		rd(OFS_STATUS, 8'h01);
		wr(OFS_MASK, 8'h01);
		check("unmasked irq", {15'h0, o_match_irq}, 16'h1);
		wr(OFS_STATUS, 8'h01);
		check("cleared irq", {15'h0, o_match_irq}, 16'h0);
		rd(OFS_STATUS, 8'h00);
		// An undecoded mode code leaves the counter and flag at rest
		start(SEL_FULL, 3'h2, 8'h03);
		repeat (10) @(posedge i_sys_clk);
		rd(OFS_COUNT, 8'h00);
		rd(OFS_STATUS, 8'h00);
		// Event counting on falling edges of the pin
		start(SEL_PIN, MODE_TIMER, 8'h03);
		tcm_evt_src_i.pulses(2, 3);
		repeat (8) @(posedge i_sys_clk);
		rd(OFS_COUNT, 8'h02);
		rd(OFS_STATUS, 8'h00);
		tcm_evt_src_i.pulses(1, 2);
		repeat (8) @(posedge i_sys_clk);
		rd(OFS_STATUS, 8'h01);
		rd(OFS_COUNT, 8'h00);
		check("event irq", {15'h0, o_match_irq}, 16'h1);
		// A match in the same cycle as a write-one clear keeps the flag
		start(SEL_FULL, MODE_TIMER, 8'h01);
		i_addr  <= OFS_STATUS;
		i_wdata <= 8'h01;
		i_wr    <= 1'b1;
		@(posedge i_sys_clk);
		i_wr    <= 1'b0;
		rd(OFS_STATUS, 8'h01);
		repeat (4) @(posedge i_sys_clk);
		end_of_test();
	end

	// Hang guard
	initial begin
		repeat (90000) @(posedge i_sys_clk);
		check("run time limit", 16'h0, 16'h1);
		end_of_test();
	end
endmodule : testbench
